// ---- core/dhi_host_port.sv ----
// Display host port: parallel, serial and pixel-stream receive logic
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Straps 000/001/010/011 give parallel bus widths 8/9/16/18 bits.
// - Straps 101 give 3-wire 9-bit serial; 111 give 4-wire 8-bit serial.
// - Parallel transfers: data/command select high is data, low is command.
// - In serial modes the data/command select pin carries the serial clock.
// - Serial input bits are sampled on the rising serial clock edge.
// - In 4-wire serial the write strobe pin selects command or parameter.
// - Serial read data leaves on its own output line, not the input line.
// - Shared 18-bit bus; direction follows read and write strobes.
// - Pixel words are taken only while data enable is high.
// - Each pixel word is timed by the rising pixel clock edge.
module dhi_host_port (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic mode_strap_hi_i,
	input wire logic mode_strap_mid_i,
	input wire logic mode_strap_lo_i,
	input wire logic host_rst_n_i,
	input wire logic cs_n_i,
	input wire logic data_command_sel_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic vsync_i,
	input wire logic hsync_i,
	input wire logic pixel_de_i,
	input wire logic pixel_clock_i,
	input wire logic sda_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic [17:0] parallel_data_bus_i,
	output logic [17:0] parallel_data_bus_o,
	output logic parallel_data_bus_oe_o,
	input wire logic pixel_mode_i,
	input wire logic serial_read_i,
	input wire logic [17:0] rd_word_i,
	output logic rd_take_o,
	output logic [17:0] word_o,
	output logic word_dc_o,
	output logic word_vld_o,
	output logic [17:0] pixel_o,
	output logic pixel_vld_o,
	output logic frame_start_o,
	output logic line_start_o,
	output logic [6:0] host_bus_mode_o
);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	dhi_sync_if #(.W(dhi_pkg::SYNC_W)) pins ();
	logic [dhi_pkg::SYNC_W-1:0] pin_vec;

	assign pin_vec = {parallel_data_bus_i, mode_strap_hi_i, mode_strap_mid_i, mode_strap_lo_i,
		host_rst_n_i, sda_i, pixel_clock_i, pixel_de_i, hsync_i, vsync_i, rd_n_i, wr_n_i,
		data_command_sel_i, cs_n_i};

	dhi_pin_sync #(.W(dhi_pkg::SYNC_W)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(pin_vec),
		.sync_o(pins.prod)
	);

	logic [17:0] bus_s;
	logic cs_act;
	logic host_rst;
	logic scl_s;
	logic sda_s;

	assign bus_s = pins.level[dhi_pkg::SI_BUS +: dhi_pkg::BUS_W];
	assign cs_act = ~pins.level[dhi_pkg::SI_CS];
	assign host_rst = ~pins.level[dhi_pkg::SI_RST];
	assign scl_s = pins.level[dhi_pkg::SI_SCL];
	assign sda_s = pins.level[dhi_pkg::SI_SDA];

	// ----------------------------------------
	// Mode straps and bus width
	// ----------------------------------------
	logic [2:0] strap_q;
	dhi_pkg::dhi_mode_t mode_d;
	dhi_pkg::dhi_mode_t mode_q;
	logic [17:0] mask;
	logic is_par;
	logic is_ser;

	// Straps are re-read only while held in reset or deselected
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_q <= dhi_pkg::STRAP_RST;
		end else if (host_rst || !cs_act) begin
			strap_q <= pins.level[dhi_pkg::SI_STRAP +: 3];
		end
	end

	always_comb begin
		unique case (strap_q)
			dhi_pkg::STRAP_P8: mode_d = dhi_pkg::MODE_P8;
			dhi_pkg::STRAP_P9: mode_d = dhi_pkg::MODE_P9;
			dhi_pkg::STRAP_P16: mode_d = dhi_pkg::MODE_P16;
			dhi_pkg::STRAP_P18: mode_d = dhi_pkg::MODE_P18;
			dhi_pkg::STRAP_S3: mode_d = dhi_pkg::MODE_S3;
			dhi_pkg::STRAP_S4: mode_d = dhi_pkg::MODE_S4;
			default: mode_d = dhi_pkg::MODE_NONE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_q <= dhi_pkg::MODE_P8;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_comb begin
		unique case (mode_q)
			dhi_pkg::MODE_P9: mask = dhi_pkg::MASK_P9;
			dhi_pkg::MODE_P16: mask = dhi_pkg::MASK_P16;
			dhi_pkg::MODE_P18: mask = dhi_pkg::MASK_P18;
			default: mask = dhi_pkg::MASK_P8;
		endcase
	end

	assign is_par = (mode_q inside {dhi_pkg::MODE_P8, dhi_pkg::MODE_P9,
		dhi_pkg::MODE_P16, dhi_pkg::MODE_P18}) && !pixel_mode_i;
	assign is_ser = (mode_q inside {dhi_pkg::MODE_S3, dhi_pkg::MODE_S4}) && !pixel_mode_i;
	assign host_bus_mode_o = mode_q;

	// ----------------------------------------
	// Parallel strobes
	// ----------------------------------------
	logic par_wr;
	logic par_rd;
	logic rd_act;

	assign par_wr = is_par && cs_act && !host_rst && pins.rise[dhi_pkg::SI_WR];
	assign par_rd = is_par && cs_act && !host_rst && pins.fall[dhi_pkg::SI_RD];
	assign rd_act = is_par && cs_act && !host_rst && !pins.level[dhi_pkg::SI_RD]
		&& pins.level[dhi_pkg::SI_WR];

	// ----------------------------------------
	// Serial receive
	// ----------------------------------------
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [3:0] last_bit;
	logic ser_live;
	logic ser_bit;
	logic ser_done;

	assign last_bit = (mode_q == dhi_pkg::MODE_S3) ? dhi_pkg::S3_LAST : dhi_pkg::S4_LAST;
	assign ser_live = is_ser && cs_act && !host_rst;
	assign ser_bit = ser_live && pins.rise[dhi_pkg::SI_SCL];
	assign ser_done = ser_bit && (cnt_q == last_bit);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= dhi_pkg::CNT_ZERO;
			sh_q <= dhi_pkg::SH_RST;
		end else if (!ser_live) begin
			cnt_q <= dhi_pkg::CNT_ZERO;
		end else if (ser_bit) begin
			sh_q <= {sh_q[6:0], sda_s};
			cnt_q <= ser_done ? dhi_pkg::CNT_ZERO : cnt_q + dhi_pkg::CNT_ONE;
		end
	end

	// ----------------------------------------
	// Serial transmit on its own output line
	// ----------------------------------------
	logic [7:0] sdo_sh_q;
	logic sdo_load;

	assign sdo_load = ser_live && (pins.fall[dhi_pkg::SI_CS] || ser_done);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sdo_sh_q <= dhi_pkg::SH_RST;
		end else if (sdo_load) begin
			sdo_sh_q <= rd_word_i[7:0];
		end else if (ser_live && pins.fall[dhi_pkg::SI_SCL]) begin
			sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sdo_o <= 1'b0;
		end else begin
			sdo_o <= sdo_sh_q[7];
		end
	end

	assign sdo_oe_o = ser_live && serial_read_i;

	// ----------------------------------------
	// Received word output
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			word_o <= dhi_pkg::WORD_RST;
			word_dc_o <= 1'b0;
			word_vld_o <= 1'b0;
		end else if (par_wr) begin
			word_o <= bus_s & mask;
			word_dc_o <= scl_s;
			word_vld_o <= 1'b1;
		end else if (ser_done) begin
			word_o <= {10'h000, sh_q[6:0], sda_s};
			if (mode_q == dhi_pkg::MODE_S4) begin
				word_dc_o <= pins.level[dhi_pkg::SI_WR];
			end else begin
				word_dc_o <= sh_q[7];
			end
			word_vld_o <= 1'b1;
		end else begin
			word_vld_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// Parallel read drive
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			parallel_data_bus_o <= dhi_pkg::WORD_RST;
		end else if (par_rd) begin
			parallel_data_bus_o <= rd_word_i & mask;
		end
	end

	assign parallel_data_bus_oe_o = rd_act;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_take_o <= 1'b0;
		end else begin
			rd_take_o <= par_rd || sdo_load;
		end
	end

	// ----------------------------------------
	// Pixel stream
	// ----------------------------------------
	logic pix_take;

	assign pix_take = pixel_mode_i && !host_rst && pins.rise[dhi_pkg::SI_PCLK]
		&& pins.level[dhi_pkg::SI_DE];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pixel_o <= dhi_pkg::WORD_RST;
			pixel_vld_o <= 1'b0;
		end else begin
			pixel_vld_o <= pix_take;
			if (pix_take) begin
				pixel_o <= bus_s;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_start_o <= 1'b0;
			line_start_o <= 1'b0;
		end else begin
			frame_start_o <= pixel_mode_i && !host_rst && pins.fall[dhi_pkg::SI_VS];
			line_start_o <= pixel_mode_i && !host_rst && pins.fall[dhi_pkg::SI_HS];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_par_width: assert property (
		par_wr |=> word_vld_o && word_o == ($past(bus_s) & $past(mask)))
		else $error("parallel word not masked to strap width");

	chk_ser_length: assert property (
		ser_done |=> word_vld_o && cnt_q == dhi_pkg::CNT_ZERO)
		else $error("serial frame did not close at its last bit");

	chk_host_reset: assert property (
		host_rst |=> !word_vld_o && cnt_q == dhi_pkg::CNT_ZERO)
		else $error("port active while host reset asserted");

	chk_par_dc: assert property (
		par_wr |=> word_dc_o == $past(scl_s))
		else $error("data/command flag does not follow select line");

	chk_scl_sample: assert property (
		ser_bit |=> sh_q[0] == $past(sda_s))
		else $error("serial bit not taken on clock rise");

	chk_four_wire_dc: assert property (
		(ser_done && mode_q == dhi_pkg::MODE_S4) |=> word_dc_o == $past(pins.level[dhi_pkg::SI_WR]))
		else $error("4-wire select line not used as command flag");

	chk_sdo_shift: assert property (
		(ser_live && !sdo_load && pins.fall[dhi_pkg::SI_SCL])
		|=> sdo_sh_q == {$past(sdo_sh_q[6:0]), 1'b0} ##1 sdo_o == $past(sdo_sh_q[7]))
		else $error("serial output shifter out of step");

	chk_bus_dir: assert property (
		parallel_data_bus_oe_o |-> !pins.level[dhi_pkg::SI_RD] && pins.level[dhi_pkg::SI_WR]
		&& !sdo_oe_o)
		else $error("data bus driven outside a read strobe");

	chk_pix_enable: assert property (
		pixel_vld_o |-> $past(pins.level[dhi_pkg::SI_DE]) && pixel_o == $past(bus_s))
		else $error("pixel taken without data enable");

	chk_pix_clock: assert property (
		pixel_vld_o |-> $past(pins.rise[dhi_pkg::SI_PCLK]) && !$past(pixel_vld_o))
		else $error("pixel not timed by pixel clock edge");

endmodule : dhi_host_port
`default_nettype wire

// ---- core/dhi_pin_sync.sv ----
// Two-stage synchroniser with edge detection for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module dhi_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] pin_i,
	dhi_sync_if.prod sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] stab_q;
	logic [W-1:0] prev_q;
	logic [2:0] fill_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			stab_q <= '0;
			prev_q <= '0;
			fill_q <= '0;
		end else begin
			meta_q <= pin_i;
			stab_q <= meta_q;
			prev_q <= stab_q;
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	assign sync_o.level = stab_q;
	// Edges held off until all stages carry pin levels: the step from the
	// reset value to a pin's idle level must not look like a strobe edge
	assign sync_o.rise = stab_q & ~prev_q & {W{fill_q[2]}};
	assign sync_o.fall = ~stab_q & prev_q & {W{fill_q[2]}};
endmodule : dhi_pin_sync
`default_nettype wire

// ---- shared/dhi_pkg.sv ----
// Constants and types shared by the display host port design
package dhi_pkg;

	// ----------------------------------------
	// Mode strap codes, ordered {hi, mid, lo}
	// ----------------------------------------
	localparam logic [2:0] STRAP_P8 = 3'h0;
	localparam logic [2:0] STRAP_P9 = 3'h1;
	localparam logic [2:0] STRAP_P16 = 3'h2;
	localparam logic [2:0] STRAP_P18 = 3'h3;
	localparam logic [2:0] STRAP_S3 = 3'h5;
	localparam logic [2:0] STRAP_S4 = 3'h7;
	localparam logic [2:0] STRAP_RST = 3'h0;

	typedef enum logic [6:0] {
		MODE_P8 = 7'h01,
		MODE_P9 = 7'h02,
		MODE_P16 = 7'h04,
		MODE_P18 = 7'h08,
		MODE_S3 = 7'h10,
		MODE_S4 = 7'h20,
		MODE_NONE = 7'h40
	} dhi_mode_t;

	// ----------------------------------------
	// Data bus widths and serial framing
	// ----------------------------------------
	localparam int BUS_W = 18;
	localparam logic [17:0] MASK_P8 = 18'h000FF;
	localparam logic [17:0] MASK_P9 = 18'h001FF;
	localparam logic [17:0] MASK_P16 = 18'h0FFFF;
	localparam logic [17:0] MASK_P18 = 18'h3FFFF;
	localparam logic [17:0] WORD_RST = 18'h00000;
	localparam logic [3:0] S3_LAST = 4'h8;
	localparam logic [3:0] S4_LAST = 4'h7;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] SH_RST = 8'h00;

	// ----------------------------------------
	// Positions in the synchronised pin vector
	// ----------------------------------------
	localparam int SI_CS = 0;
	localparam int SI_SCL = 1;
	localparam int SI_WR = 2;
	localparam int SI_RD = 3;
	localparam int SI_VS = 4;
	localparam int SI_HS = 5;
	localparam int SI_DE = 6;
	localparam int SI_PCLK = 7;
	localparam int SI_SDA = 8;
	localparam int SI_RST = 9;
	localparam int SI_STRAP = 10;
	localparam int SI_BUS = 13;
	localparam int SYNC_W = 31;

endpackage : dhi_pkg

// ---- shared/dhi_sync_if.sv ----
// Interface carrying synchronised pin levels and their edges
`timescale 1ns/1ps
`default_nettype none
interface dhi_sync_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport prod (output level, output rise, output fall);
	modport cons (input level, input rise, input fall);
endinterface : dhi_sync_if
`default_nettype wire

// ---- verification/dhi_host.sv ----
// Host controller and pixel source model for the display host port
`timescale 1ns/1ps
`default_nettype none
module dhi_host (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic rst_n_o,
	output logic cs_n_o,
	output logic dcs_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic sda_o,
	output logic vs_o,
	output logic hs_o,
	output logic de_o,
	output logic pclk_o,
	output logic [17:0] bus_o
);
	logic keep_cs;
	// ----------------------------------------
	// Idle levels, device held in reset
	// ----------------------------------------
	initial begin
		{rst_n_o, cs_n_o, dcs_o, wr_n_o, rd_n_o} = 5'h0B;
		{sda_o, vs_o, hs_o, de_o, pclk_o} = 5'h1C;
		bus_o = 18'h3FFFF;
		keep_cs = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : tick
	task automatic release_rst();
		rst_n_o = 1'b1;
		tick(6);
	endtask : release_rst
	task automatic hold_cs(input logic on);
		keep_cs = on;
		cs_n_o = ~on;
		tick(4);
	endtask : hold_cs
	// ----------------------------------------
	// Host transfers
	// ----------------------------------------
	task automatic par_xfer(input logic rd, input logic dc, input logic [17:0] d);
		cs_n_o = 1'b0;
		dcs_o = dc;
		bus_o = d;
		rd_n_o = ~rd;
		wr_n_o = rd;
		tick(4);
		{wr_n_o, rd_n_o} = 2'h3;
		tick(4);
		{cs_n_o, dcs_o, bus_o} = {~keep_cs, 1'b0, ~d};
		tick(4);
	endtask : par_xfer
	task automatic ser_frame(input logic four, input logic [8:0] b, output logic [7:0] so);
		cs_n_o = 1'b0;
		wr_n_o = four ? b[8] : 1'b1;
		so = 8'h00;
		tick(3);
		for (int i = four ? 7 : 8; i >= 0; i--) begin
			sda_o = b[i];
			tick(5);
			so = {so[6:0], sdo_i};
			dcs_o = 1'b1;
			tick(3);
			dcs_o = 1'b0;
		end
		tick(4);
		{cs_n_o, wr_n_o, sda_o} = {2'h3, ~sda_o};
		tick(4);
	endtask : ser_frame
	// ----------------------------------------
	// Pixel source
	// ----------------------------------------
	task automatic marks();
		vs_o = 1'b0;
		tick(4);
		{vs_o, hs_o} = 2'h2;
		tick(4);
		hs_o = 1'b1;
		tick(4);
	endtask : marks
	task automatic pixel(input logic de, input logic [17:0] d);
		{de_o, bus_o} = {de, d};
		tick(4);
		pclk_o = 1'b1;
		tick(4);
		pclk_o = 1'b0;
	endtask : pixel
endmodule : dhi_host
`default_nettype wire

// ---- verification/tb_dhi_host_port.sv ----
// Self-checking testbench for the display host port
`timescale 1ns/1ps
`default_nettype none
module tb_dhi_host_port;
	logic clk_i, sys_rst_i, mode_strap_hi_i, mode_strap_mid_i, mode_strap_lo_i;
	logic host_rst_n_i, cs_n_i, data_command_sel_i, wr_n_i, rd_n_i, vsync_i, hsync_i;
	logic pixel_de_i, pixel_clock_i, sda_i, sdo_o, sdo_oe_o, parallel_data_bus_oe_o;
	logic pixel_mode_i, serial_read_i, rd_take_o, word_dc_o, word_vld_o, pixel_vld_o;
	logic frame_start_o, line_start_o, ser;
	logic [17:0] mbus, parallel_data_bus_o, rd_word_i, word_o, pixel_o;
	logic [6:0] host_bus_mode_o;
	logic [7:0] lf, so;
	wire logic [17:0] parallel_data_bus_i;
	logic [20:0] exp_q[$];
	int n_mismatch, comparisons, n_fr, n_ln, n_oe, n_boe;
	localparam logic [2:0] STRAPS [4] = '{dhi_pkg::STRAP_P8, dhi_pkg::STRAP_P9,
		dhi_pkg::STRAP_P16, dhi_pkg::STRAP_P18};
	localparam logic [6:0] MODES [4] = '{dhi_pkg::MODE_P8, dhi_pkg::MODE_P9,
		dhi_pkg::MODE_P16, dhi_pkg::MODE_P18};
	localparam logic [17:0] MASKS [4] = '{dhi_pkg::MASK_P8, dhi_pkg::MASK_P9,
		dhi_pkg::MASK_P16, dhi_pkg::MASK_P18};
	initial clk_i = 1'b0;
	always #12.5 clk_i = ~clk_i;
	assign parallel_data_bus_i = parallel_data_bus_oe_o ? parallel_data_bus_o : mbus;
	dhi_host_port dhi_host_port_inst (.clk_i, .sys_rst_i, .mode_strap_hi_i, .mode_strap_mid_i,
		.mode_strap_lo_i, .host_rst_n_i, .cs_n_i, .data_command_sel_i, .wr_n_i, .rd_n_i,
		.vsync_i, .hsync_i, .pixel_de_i, .pixel_clock_i, .sda_i, .sdo_o, .sdo_oe_o,
		.parallel_data_bus_i, .parallel_data_bus_o, .parallel_data_bus_oe_o, .pixel_mode_i,
		.serial_read_i, .rd_word_i, .rd_take_o, .word_o, .word_dc_o, .word_vld_o, .pixel_o,
		.pixel_vld_o, .frame_start_o, .line_start_o, .host_bus_mode_o);
	dhi_host dhi_host_inst (.clk_i, .sdo_i(sdo_o), .rst_n_o(host_rst_n_i), .cs_n_o(cs_n_i),
		.dcs_o(data_command_sel_i), .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .sda_o(sda_i),
		.vs_o(vsync_i), .hs_o(hsync_i), .de_o(pixel_de_i), .pclk_o(pixel_clock_i), .bus_o(mbus));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction : rnd
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask : chk
	task automatic take(input logic [20:0] got);
		if (exp_q.size() == 0) chk(1'b0, "unexpected output");
		else chk(exp_q.pop_front() === got, "output value");
	endtask : take
	task automatic set_mode(input logic [2:0] s, input logic [6:0] em);
		{mode_strap_hi_i, mode_strap_mid_i, mode_strap_lo_i} = s;
		dhi_host_inst.tick(6);
		chk(host_bus_mode_o === em, "bus mode");
	endtask : set_mode
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// Result watcher, oldest note first
	always @(posedge clk_i) begin
		if (word_vld_o === 1'b1) take({2'h0, word_dc_o, ser ? {10'h000, word_o[7:0]} : word_o});
		if (rd_take_o === 1'b1) begin
			take(ser ? {3'h5, 10'h000, rd_word_i[7:0]} : {3'h4, parallel_data_bus_o});
		end
		if (pixel_vld_o === 1'b1) take({3'h6, pixel_o});
		n_fr += int'(frame_start_o === 1'b1);
		n_ln += int'(line_start_o === 1'b1);
		n_oe += int'(sdo_oe_o === 1'b1);
		n_boe += int'(parallel_data_bus_oe_o === 1'b1);
	end
	initial begin
		#200us;
		n_mismatch++;
		complete_run();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [23:0] r;
		lf = 8'h3A;
		{sys_rst_i, pixel_mode_i, serial_read_i, ser} = 4'h8;
		rd_word_i = 18'h00000;
		{mode_strap_hi_i, mode_strap_mid_i, mode_strap_lo_i} = dhi_pkg::STRAP_P8;
		repeat (16) @(posedge clk_i);
		#2;
		sys_rst_i = 1'b0;
		dhi_host_inst.tick(4);
		dhi_host_inst.par_xfer(1'b0, 1'b1, 18'h0005A);
		dhi_host_inst.release_rst();
		for (int k = 0; k < 4; k++) begin
			set_mode(STRAPS[k], MODES[k]);
			for (int j = 0; j < 2; j++) begin
				r = {rnd(), rnd(), rnd()};
				exp_q.push_back({2'h0, j[0], r[17:0] & MASKS[k]});
				dhi_host_inst.par_xfer(1'b0, j[0], r[17:0]);
			end
			rd_word_i = ~r[17:0];
			exp_q.push_back({3'h4, rd_word_i & MASKS[k]});
			dhi_host_inst.par_xfer(1'b1, 1'b1, r[17:0]);
		end
		dhi_host_inst.hold_cs(1'b1);
		for (int j = 0; j < 2; j++) begin
			r = {rnd(), rnd(), rnd()};
			exp_q.push_back({3'h1, r[17:0]});
			dhi_host_inst.par_xfer(1'b0, 1'b1, r[17:0]);
		end
		dhi_host_inst.hold_cs(1'b0);
		set_mode(3'h4, dhi_pkg::MODE_NONE);
		dhi_host_inst.par_xfer(1'b0, 1'b1, 18'h00033);
		ser = 1'b1;
		set_mode(dhi_pkg::STRAP_S3, dhi_pkg::MODE_S3);
		exp_q.push_back({3'h5, 10'h000, rd_word_i[7:0]});
		dhi_host_inst.par_xfer(1'b0, 1'b0, 18'h00011);
		for (int k = 0; k < 4; k++) begin
			if (k == 2) begin
				set_mode(dhi_pkg::STRAP_S4, dhi_pkg::MODE_S4);
				serial_read_i = 1'b1;
			end
			r = {rnd(), rnd(), rnd()};
			rd_word_i = r[17:0];
			exp_q.push_back({3'h5, 10'h000, r[7:0]});
			exp_q.push_back({2'h0, r[8], 10'h000, r[7:0]});
			exp_q.push_back({3'h5, 10'h000, r[7:0]});
			dhi_host_inst.ser_frame(k > 1, r[8:0], so);
			if (k > 1) chk(so === rd_word_i[7:0], "serial read data");
		end
		{ser, serial_read_i, pixel_mode_i} = 3'h1;
		set_mode(dhi_pkg::STRAP_P18, dhi_pkg::MODE_P18);
		dhi_host_inst.marks();
		for (int k = 0; k < 4; k++) begin
			r = {rnd(), rnd(), rnd()};
			if (k < 3) exp_q.push_back({3'h6, r[17:0]});
			dhi_host_inst.pixel(k < 3, r[17:0]);
		end
		dhi_host_inst.tick(8);
		chk(n_fr == 1 && n_ln == 1, "sync marks");
		chk(n_oe == 142 && n_boe == 16, "output enables");
		chk(exp_q.size() == 0, "missing output");
		complete_run();
	end
endmodule : tb_dhi_host_port
`default_nettype wire
